/* paravirt_pci_header_regs.sv */
/*
 * Common header of a paravirtual PCI device in its first I/O region,
 * followed by a byte-addressed device-specific region.
 * Assumes the PCI target logic presents one access per strobe, dword
 * aligned with byte enables, and that MSI-X enable comes from config space.
 */
`timescale 1ns/1ps
`include "pvh_defs.svh"

////////////////////////////////////////////////////////////////////////
// What this block does
// - Report fixed vendor code, device code in reserved range, one revision.
// - Subsystem device code names the device type implemented.
// - Common header first in I/O region, device region right after it.
// - Device region accepts any width and gives consistent results.
// - Header little-endian; device region bytes kept in guest order.
// - Header order: features, guest features, page, size, select, kick...
// - With MSI-X on, two vector fields follow; otherwise later fields move.
// - Extended flag adds upper offered and accepted feature words.
// - Writing zero to status resets the device.
// - Status bits: found 1, driver-known 2, ready 4, gave-up 128.
// - After gave-up a reset is needed before initializing again.
// - Written status is kept and reads back as progress record.
// - Guest writes accepted features; renegotiation only by reset, though a rewrite is taken at any time.
// - Vectors take 0..0x7FF, else read 0xFFFF; all start unmapped.
// - Upper features count as unaccepted unless accepted bit 31 set.
// - Selected queue size is power of two or zero; address is page.
module paravirt_pci_header_regs
	import pvh_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE    = 16'h0ABC, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE    = 16'h0DEF, // Arbitrary value
	parameter logic [7:0]  REVISION_CODE  = 8'h5A,    // Arbitrary value
	parameter logic [15:0] SUBSYS_DEVICE  = 16'h0001  // Device type code
)
(
	input  wire logic        mclk,            // 250 MHz clock
	input  wire logic        rst,             // Sync reset, high
	input  io_req_t          io_req,          // I/O region access
	output io_rsp_t          io_rsp,          // Access answer
	input  wire logic        msix_enabled,    // MSI-X on in config space
	input  wire logic [31:0] offered_low,     // Device features 0..31
	input  wire logic [31:0] offered_high,    // Device features 32..63
	input  wire logic        vector_fail,     // Mapping resources exhausted
	input  wire logic        queue_event,     // Used ring updated, pulse
	input  wire logic        config_event,    // Config changed, pulse
	output logic [15:0]      vendor_code,     // PCI identity
	output logic [15:0]      device_code,     // PCI identity
	output logic [7:0]       revision_code,   // PCI identity
	output logic [15:0]      subsys_device,   // Device type
	output logic [63:0]      accepted,        // Effective accepted features
	output logic [7:0]       driver_status,   // Stored progress record
	output logic             device_ready,    // Ready and not given up
	output logic             soft_reset,      // Status-zero reset, pulse
	output kick_t            kick,            // Queue notify
	output logic [15:0]      config_vector,   // Config change vector
	output logic             int_pending      // Legacy interrupt level
);

	////////////////////////////////////////////////////////////////////
	// State

	logic [31:0]  accepted_features_low;
	logic [31:0]  accepted_features_high;
	logic [15:0]  queue_index_select;
	logic [15:0]  queue_kick;
	logic [7:0]   driver_progress;
	logic [7:0]   interrupt_cause;
	logic [15:0]  config_change_vector;
	logic [7:0]   dev_mem [`DEV_BYTES];
	queue_entry_t entry;

	logic [7:0]   lane_addr [4];
	logic [3:0]   wr_lane;
	logic [3:0]   rd_lane;
	logic         ext_on;
	logic [7:0]   off_hi;
	logic [7:0]   off_dev;
	logic [31:0]  next_page;
	logic [31:0]  next_qvec_raw;
	logic [31:0]  next_cvec_raw;
	logic [15:0]  next_qvec;
	logic [15:0]  next_cvec;
	logic         page_we;
	logic         qvec_we;
	logic         status_hit;
	logic [7:0]   status_byte;
	logic         cause_read;

	assign ext_on  = offered_low[`EXT_FEATURE_BIT];
	assign off_hi  = msix_enabled ? (`LEN_COMMON + `LEN_VECTORS) : `LEN_COMMON;
	assign off_dev = ext_on ? (off_hi + `LEN_FEAT_HI) : off_hi;

	always_comb
	begin
		for (int l = 0; l < 4; l++)
		begin
			lane_addr[l] = io_req.addr + 8'(l);
			wr_lane[l]   = io_req.valid && io_req.write && io_req.be[l];
			rd_lane[l]   = io_req.valid && !io_req.write && io_req.be[l];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Decode helpers

	// True when address a falls in [base, base+len)
	function automatic logic in_field(input logic [7:0] a, input logic [7:0] base,
		input logic [7:0] len);
		in_field = (a >= base) && (a < base + len);
	endfunction

	// Merge written lanes into a field, little-endian byte order
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [7:0] base, input logic [7:0] len);
		logic [31:0] v;
		logic [7:0]  k;
		v = old;
		for (int l = 0; l < 4; l++)
		begin
			k = lane_addr[l] - base;
			if (wr_lane[l] && in_field(lane_addr[l], base, len))
				v[k[1:0]*8 +: 8] = io_req.wdata[l*8 +: 8];
		end
		merge = v;
	endfunction

	function automatic logic hit(input logic [7:0] base, input logic [7:0] len);
		hit = 1'b0;
		for (int l = 0; l < 4; l++)
			if (wr_lane[l] && in_field(lane_addr[l], base, len))
				hit = 1'b1;
	endfunction

	// Out-of-range or unplaceable vectors read back as unmapped
	function automatic logic [15:0] check_vec(input logic [15:0] v);
		check_vec = (v > `VEC_MAX || vector_fail) ? `NO_VECTOR : v;
	endfunction

	////////////////////////////////////////////////////////////////////
	// Write decode

	always_comb
	begin
		next_page     = merge(entry.page, `OFF_QUEUE_PAGE, 8'h04);
		next_qvec_raw = merge({16'h0000, entry.vector}, `OFF_QUEUE_VEC, 8'h02);
		next_cvec_raw = merge({16'h0000, config_change_vector}, `OFF_CFG_VEC, 8'h02);
		next_qvec     = check_vec(next_qvec_raw[15:0]);
		next_cvec     = check_vec(next_cvec_raw[15:0]);
		page_we       = hit(`OFF_QUEUE_PAGE, 8'h04);
		qvec_we       = msix_enabled && hit(`OFF_QUEUE_VEC, 8'h02);
		status_hit    = hit(`OFF_STATUS, 8'h01);
		status_byte   = io_req.wdata[23:16];
		cause_read    = rd_lane[3] && lane_addr[3] == `OFF_INT_CAUSE && !msix_enabled;
	end

	// Zero written to status is the device reset
	logic soft_reset_next;
	assign soft_reset_next = status_hit && status_byte == 8'h00;

	always_ff @(posedge mclk)
	begin
		if (rst)
			soft_reset <= 1'b0;
		else
			soft_reset <= soft_reset_next;
	end

	////////////////////////////////////////////////////////////////////
	// Status and progress record

	always_ff @(posedge mclk)
	begin
		if (rst || soft_reset_next)
			driver_progress <= `RST_STATUS;
		else if (status_hit)
			// Gave-up sticks until a zero write clears it
			driver_progress <= status_byte
				| (driver_progress & (8'h01 << `ST_GAVE_UP));
	end

	assign driver_status = driver_progress;
	assign device_ready  = driver_progress[`ST_READY] && !driver_progress[`ST_GAVE_UP];

	////////////////////////////////////////////////////////////////////
	// Feature negotiation

	always_ff @(posedge mclk)
	begin
		if (rst || soft_reset_next)
		begin
			accepted_features_low  <= 32'h0000_0000;
			accepted_features_high <= 32'h0000_0000;
		end
		else
		begin
			accepted_features_low <= merge(accepted_features_low, `OFF_GUEST_LO, 8'h04);
			if (ext_on)
				accepted_features_high <= merge(accepted_features_high,
					off_hi + 8'h04, 8'h04);
		end
	end

	assign accepted = {accepted_features_low[`EXT_FEATURE_BIT]
		? accepted_features_high : 32'h0000_0000, accepted_features_low};

	////////////////////////////////////////////////////////////////////
	// Queue select, kick, vectors

	always_ff @(posedge mclk)
	begin
		if (rst || soft_reset_next)
		begin
			queue_index_select   <= 16'h0000;
			config_change_vector <= `NO_VECTOR;
		end
		else
		begin
			queue_index_select <= 16'(merge({16'h0000, queue_index_select},
				`OFF_QUEUE_SEL, 8'h02));
			if (msix_enabled && hit(`OFF_CFG_VEC, 8'h02))
				config_change_vector <= next_cvec;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			queue_kick <= 16'h0000;
			kick       <= '0;
		end
		else
		begin
			kick.valid <= hit(`OFF_QUEUE_KICK, 8'h02);
			kick.index <= 16'(merge({16'h0000, queue_kick}, `OFF_QUEUE_KICK, 8'h02));
			queue_kick <= 16'(merge({16'h0000, queue_kick}, `OFF_QUEUE_KICK, 8'h02));
		end
	end

	assign config_vector = config_change_vector;

	pvh_queue_table u_queues (
		.mclk    (mclk),
		.rst     (rst),
		.clear   (soft_reset_next),
		.sel     (queue_index_select),
		.page_we (page_we),
		.page_in (next_page),
		.vec_we  (qvec_we),
		.vec_in  (next_qvec),
		.entry   (entry)
	);

	////////////////////////////////////////////////////////////////////
	// Interrupt cause, cleared by reading it while MSI-X is off

	always_ff @(posedge mclk)
	begin
		if (rst || soft_reset_next)
			interrupt_cause <= 8'h00;
		else
		begin
			// A new event in the clearing cycle survives the read
			interrupt_cause <= (cause_read ? 8'h00 : interrupt_cause)
				| (8'(queue_event) << `CAUSE_QUEUE)
				| (8'(config_event) << `CAUSE_CONFIG);
		end
	end

	// With MSI-X on the cause field is unused
	assign int_pending = !msix_enabled && interrupt_cause != 8'h00;

	////////////////////////////////////////////////////////////////////
	// Device-specific region: plain bytes, any access width

	genvar d;
	generate
		for (d = 0; d < `DEV_BYTES; d++)
		begin : g_dev
			always_ff @(posedge mclk)
			begin
				if (rst)
					dev_mem[d] <= 8'h00;
				else
					for (int l = 0; l < 4; l++)
						if (wr_lane[l] && lane_addr[l] == off_dev + 8'(d))
							dev_mem[d] <= io_req.wdata[l*8 +: 8];
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Read path

	function automatic logic [7:0] read_byte(input logic [7:0] a);
		logic [7:0] k;
		read_byte = 8'h00;
		k = a - off_dev;
		if (a < `LEN_COMMON)
			unique case (a[4:2])
				3'd0: read_byte = offered_low[a[1:0]*8 +: 8];
				3'd1: read_byte = accepted_features_low[a[1:0]*8 +: 8];
				3'd2: read_byte = entry.page[a[1:0]*8 +: 8];
				3'd3: read_byte = a[1] ? queue_index_select[a[0]*8 +: 8]
					: entry.size[a[0]*8 +: 8];
				default: read_byte = a[1] ? (a[0] ? interrupt_cause : driver_progress)
					: queue_kick[a[0]*8 +: 8];
			endcase
		else if (msix_enabled && a < off_hi)
			read_byte = a[1] ? entry.vector[a[0]*8 +: 8]
				: config_change_vector[a[0]*8 +: 8];
		else if (ext_on && a < off_dev)
			read_byte = (a[2] ^ off_hi[2]) ? accepted_features_high[a[1:0]*8 +: 8]
				: offered_high[a[1:0]*8 +: 8];
		else if (k < 8'(`DEV_BYTES))
			read_byte = dev_mem[k[4:0]];
	endfunction

	always_ff @(posedge mclk)
	begin
		if (rst)
			io_rsp <= '0;
		else
		begin
			io_rsp.ack <= io_req.valid;
			for (int l = 0; l < 4; l++)
				io_rsp.rdata[l*8 +: 8] <= rd_lane[l] ? read_byte(lane_addr[l]) : 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Identity

	assign vendor_code   = VENDOR_CODE;
	assign device_code   = DEVICE_CODE;
	assign revision_code = REVISION_CODE;
	assign subsys_device = SUBSYS_DEVICE;

endmodule

/* pvh_defs.svh */
/*
 * Offsets, field positions, reset values and sizes of the paravirtual
 * PCI common header. Assumes byte addresses within the first I/O region.
 */
`ifndef PVH_DEFS_SVH
`define PVH_DEFS_SVH

`define OFF_FEAT_LO      8'h00
`define OFF_GUEST_LO     8'h04
`define OFF_QUEUE_PAGE   8'h08
`define OFF_QUEUE_SIZE   8'h0C
`define OFF_QUEUE_SEL    8'h0E
`define OFF_QUEUE_KICK   8'h10
`define OFF_STATUS       8'h12
`define OFF_INT_CAUSE    8'h13
`define OFF_CFG_VEC      8'h14
`define OFF_QUEUE_VEC    8'h16
`define LEN_COMMON       8'h14
`define LEN_VECTORS      8'h04
`define LEN_FEAT_HI      8'h08

`define ST_FOUND         0
`define ST_DRIVER        1
`define ST_READY         2
`define ST_GAVE_UP       7
`define RST_STATUS       8'h00

`define CAUSE_QUEUE      0
`define CAUSE_CONFIG     1

`define EXT_FEATURE_BIT  31
`define NO_VECTOR        16'hFFFF
`define VEC_MAX          16'h07FF
`define RST_PAGE         32'h0000_0000

`define NUM_QUEUES       4
`define QSEL_W           2
`define QUEUE_SIZE       16'h0100
`define DEV_BYTES        32
`define PAGE_SHIFT       12

`endif

/* pvh_hdr_chk.sv */
/*
 * Port assertions for the common header register bank.
 * Assumes one clock, mclk, and the synchronous high reset rst.
 */
`timescale 1ns/1ps
module pvh_hdr_chk
	import pvh_pkg::*;
#(
	parameter logic [15:0] VENDOR_CODE   = 16'h0ABC, // Arbitrary value
	parameter logic [15:0] DEVICE_CODE   = 16'h0DEF, // Arbitrary value
	parameter logic [7:0]  REVISION_CODE = 8'h5A,    // Arbitrary value
	parameter logic [15:0] SUBSYS_DEVICE = 16'h0001  // Device type
)
(
	input wire logic        mclk,          // Clock
	input wire logic        rst,           // Sync reset
	input io_req_t          io_req,        // Access
	input io_rsp_t          io_rsp,        // Answer
	input wire logic        msix_enabled,  // MSI-X on
	input wire logic [31:0] offered_low,   // Offered low
	input wire logic [31:0] offered_high,  // Offered high
	input wire logic        vector_fail,   // Mapping fails
	input wire logic        queue_event,   // Queue event
	input wire logic        config_event,  // Config event
	input wire logic [15:0] vendor_code,   // Identity
	input wire logic [15:0] device_code,   // Identity
	input wire logic [7:0]  revision_code, // Identity
	input wire logic [15:0] subsys_device, // Device type
	input wire logic [63:0] accepted,      // Accepted features
	input wire logic [7:0]  driver_status, // Progress record
	input wire logic        device_ready,  // Ready
	input wire logic        soft_reset,    // Reset pulse
	input kick_t            kick,          // Notify
	input wire logic [15:0] config_vector, // Config vector
	input wire logic        int_pending    // Legacy interrupt
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////
	sequence s_status_wr;
		io_req.valid && io_req.write && io_req.addr == 8'h10 && io_req.be[2];
	endsequence
	sequence s_zero_wr;
		s_status_wr ##0 io_req.wdata[23:16] == 8'h00;
	endsequence
	sequence s_kept_wr;
		s_status_wr ##0 (io_req.wdata[23:16] != 8'h00 && !driver_status[7]);
	endsequence
	sequence s_kick_wr;
		io_req.valid && io_req.write && io_req.addr == 8'h10 && io_req.be == 4'h3;
	endsequence
	a_ack_one_late: assert property (io_req.valid |=> io_rsp.ack)
		else $error("ack missing after access");
	a_ack_only_asked: assert property (!io_req.valid |=> !io_rsp.ack)
		else $error("ack without access");
	a_zero_resets: assert property (s_zero_wr |=> soft_reset
		&& driver_status == 8'h00)
		else $error("zero status write did not reset");
	a_reset_pulse: assert property (soft_reset |=> !soft_reset)
		else $error("reset pulse too long");
	a_status_kept: assert property (s_kept_wr
		|=> driver_status == $past(io_req.wdata[23:16]))
		else $error("status not stored");
	a_gave_up_sticky: assert property (driver_status[7] && !io_req.valid
		|=> driver_status[7])
		else $error("gave-up lost without reset");
	a_ready_decode: assert property (device_ready
		== (driver_status[2] && !driver_status[7]))
		else $error("ready decode wrong");
	a_ident_fixed: assert property (vendor_code == VENDOR_CODE
		&& device_code == DEVICE_CODE && revision_code == REVISION_CODE
		&& subsys_device == SUBSYS_DEVICE)
		else $error("identity wrong");
	a_upper_gated: assert property (!accepted[31] |-> accepted[63:32] == 32'h0)
		else $error("upper features without bit 31");
	a_kick_value: assert property (s_kick_wr |=> kick.valid
		&& kick.index == $past(io_req.wdata[15:0]))
		else $error("kick wrong");
	a_vec_range: assert property (config_vector == 16'hFFFF
		|| config_vector <= 16'h07FF)
		else $error("vector out of range");
endmodule

bind paravirt_pci_header_regs pvh_hdr_chk #(.VENDOR_CODE(VENDOR_CODE),
	.DEVICE_CODE(DEVICE_CODE), .REVISION_CODE(REVISION_CODE),
	.SUBSYS_DEVICE(SUBSYS_DEVICE)) u_chk (.mclk, .rst, .io_req, .io_rsp,
	.msix_enabled, .offered_low, .offered_high, .vector_fail, .queue_event,
	.config_event, .vendor_code, .device_code, .revision_code, .subsys_device,
	.accepted, .driver_status, .device_ready, .soft_reset, .kick, .config_vector,
	.int_pending);

/* pvh_host_model.sv */
/*
 * Behavioural PCI host that issues single accesses to the I/O region.
 * Assumes the one-cycle strobe and the ack one cycle later.
 */
`timescale 1ns/1ps
module pvh_host_model
	import pvh_pkg::*;
(
	input  wire logic mclk,   // Clock
	output io_req_t   io_req, // Access to the device
	input  io_rsp_t   io_rsp  // Answer
);
	initial io_req = '0;
	////////////////////////////////////////////////////////////
	// Field-width access: the caller gives the lanes of one field
	// Same accesses whatever device code is reported
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		@(posedge mclk);
		#1;
		io_req <= '{1'b1, wr, addr, be, wd};
		@(posedge mclk);
		#1;
		// Released lines show garbage, not the last value
		io_req <= '{1'b0, ~wr, ~addr, ~be, ~wd};
		rd = io_rsp.rdata;
	endtask
endmodule

/* pvh_pkg.sv */
/*
 * Types shared by the header register bank and its queue table.
 * Assumes pvh_defs.svh is on the include path.
 */
`include "pvh_defs.svh"

package pvh_pkg;

	typedef struct packed {
		logic        valid;   // Access strobe, one cycle
		logic        write;   // 1 write, 0 read
		logic [7:0]  addr;    // Dword-aligned byte address
		logic [3:0]  be;      // Byte lanes, lane 0 = lowest address
		logic [31:0] wdata;   // Little-endian write data
	} io_req_t;

	typedef struct packed {
		logic        ack;     // One cycle after the strobe
		logic [31:0] rdata;   // Read data, lanes as in the request
	} io_rsp_t;

	typedef struct packed {
		logic                 valid;  // One-cycle kick
		logic [15:0]          index;  // Queue named by the host
	} kick_t;

	typedef struct packed {
		logic [31:0] page;    // Queue base address / 4096
		logic [15:0] vector;  // Mapped table entry or no-vector
		logic [15:0] size;    // Entry count, zero if absent
	} queue_entry_t;

endpackage

/* pvh_queue_table.sv */
/*
 * Per-queue page address and vector storage, indexed by queue select.
 * Assumes the owner has already validated vectors and merged byte lanes.
 */
`timescale 1ns/1ps
`include "pvh_defs.svh"

module pvh_queue_table
	import pvh_pkg::*;
(
	input  wire logic                 mclk,      // Clock
	input  wire logic                 rst,       // Sync reset, high
	input  wire logic                 clear,     // Device reset pulse
	input  wire logic [15:0]          sel,       // Selected queue
	input  wire logic                 page_we,   // Write page of sel
	input  wire logic [31:0]          page_in,   // New page
	input  wire logic                 vec_we,    // Write vector of sel
	input  wire logic [15:0]          vec_in,    // New vector
	output queue_entry_t              entry      // Entry of sel
);

	logic [31:0] page_mem [`NUM_QUEUES];
	logic [15:0] vec_mem  [`NUM_QUEUES];
	logic        sel_ok;
	logic [`QSEL_W-1:0] idx;

	assign sel_ok = (sel < 16'(`NUM_QUEUES));
	assign idx    = sel[`QSEL_W-1:0];

	genvar q;
	generate
		for (q = 0; q < `NUM_QUEUES; q++)
		begin : g_q
			always_ff @(posedge mclk)
			begin
				if (rst || clear)
				begin
					page_mem[q] <= `RST_PAGE;
					vec_mem[q]  <= `NO_VECTOR;
				end
				else if (sel_ok && idx == `QSEL_W'(q))
				begin
					if (page_we)
						page_mem[q] <= page_in;
					if (vec_we)
						vec_mem[q] <= vec_in;
				end
			end
		end
	endgenerate

	// Absent queues read as size zero and unmapped
	always_comb
	begin
		entry.page   = sel_ok ? page_mem[idx] : 32'h0000_0000;
		entry.vector = sel_ok ? vec_mem[idx] : `NO_VECTOR;
		entry.size   = sel_ok ? `QUEUE_SIZE : 16'h0000;
	end

endmodule

/* tb_top.sv */
/*
 * Self-checking bench for the common header register bank.
 * Assumes the host model for accesses and the bound checker.
 */
`timescale 1ns/1ps
module tb_top;
	import pvh_pkg::*;
	typedef struct {logic [7:0] addr; logic [3:0] be; logic [31:0] exp;} row_t;
	logic        mclk, rst, msix_enabled, vector_fail, queue_event, config_event;
	logic [31:0] offered_low, offered_high, rd;
	logic [15:0] vendor_code, device_code, subsys_device, config_vector;
	logic [7:0]  revision_code, driver_status;
	logic [63:0] accepted;
	logic        device_ready, soft_reset, int_pending;
	io_req_t     io_req;
	io_rsp_t     io_rsp;
	kick_t       kick;
	int          errors, n_checks;
	row_t        rows[9] = '{'{8'h00, 4'hF, 32'h0000_00F1}, '{8'h04, 4'hF, 32'h0},
		'{8'h08, 4'hF, 32'h0}, '{8'h0C, 4'h3, 32'h0000_0100}, '{8'h0C, 4'hC, 32'h0},
		'{8'h10, 4'h3, 32'h0}, '{8'h10, 4'h4, 32'h0}, '{8'h10, 4'h8, 32'h0},
		'{8'h14, 4'hF, 32'h0}};

	paravirt_pci_header_regs dut (.mclk, .rst, .io_req, .io_rsp, .msix_enabled,
		.offered_low, .offered_high, .vector_fail, .queue_event, .config_event,
		.vendor_code, .device_code, .revision_code, .subsys_device, .accepted,
		.driver_status, .device_ready, .soft_reset, .kick, .config_vector, .int_pending);
	pvh_host_model host (.mclk, .io_req, .io_rsp);

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		host.xfer(1'b1, a, be, d, rd);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [3:0] be, input logic [31:0] e);
		host.xfer(1'b0, a, be, 32'h0, rd);
		check(rd, e);
	endtask
	task automatic stw(input logic [7:0] v);
		wr(8'h10, 4'h4, {8'h00, v, 16'h0000});
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (5000) @(posedge mclk);
		errors++;
		print_verdict();
	end
	initial
	begin
		rst = 1'b1;
		msix_enabled = 1'b0;
		offered_low = 32'h0000_00F1;
		offered_high = 32'h0000_0003;
		vector_fail = 1'b0;
		queue_event = 1'b0;
		config_event = 1'b0;
		repeat (4) @(posedge mclk);
		#1 rst = 1'b0;
		foreach (rows[i])
			rdchk(rows[i].addr, rows[i].be, rows[i].exp);
		// Driver bring-up order, then gave-up and reset
		stw(8'h01);
		stw(8'h03);
		rdchk(8'h10, 4'h4, 32'h0003_0000);
		check(device_ready, 64'h0);
		wr(8'h04, 4'hF, 32'h0000_0011);
		stw(8'h07);
		check(accepted, 64'h11);
		check(driver_status, 64'h07);
		check(device_ready, 64'h1);
		stw(8'h87);
		check(device_ready, 64'h0);
		stw(8'h07);
		check(driver_status, 64'h87);
		stw(8'h00);
		check(soft_reset, 64'h1);
		check(driver_status, 64'h0);
		check(accepted, 64'h0);
		// Upper feature words, then vector fields with MSI-X on
		offered_low = 32'h8000_00F1;
		rdchk(8'h14, 4'hF, 32'h0000_0003);
		wr(8'h18, 4'hF, 32'hFFFF_FFFF);
		check(accepted, 64'h0);
		wr(8'h04, 4'hF, 32'h8000_0011);
		check(accepted, 64'hFFFF_FFFF_8000_0011);
		msix_enabled = 1'b1;
		rdchk(8'h14, 4'h3, 32'h0000_FFFF);
		rdchk(8'h14, 4'hC, 32'hFFFF_0000);
		rdchk(8'h18, 4'hF, 32'h0000_0003);
		wr(8'h14, 4'h3, 32'h0000_07FF);
		wr(8'h14, 4'hC, 32'h0800_0000);
		rdchk(8'h14, 4'h3, 32'h0000_07FF);
		rdchk(8'h14, 4'hC, 32'hFFFF_0000);
		vector_fail = 1'b1;
		wr(8'h14, 4'h3, 32'h0000_0005);
		check(config_vector, 64'hFFFF);
		vector_fail = 1'b0;
		msix_enabled = 1'b0;
		rdchk(8'h14, 4'hF, 32'h0000_0003);
		// Queue select, page and size, used before ready
		wr(8'h0C, 4'hC, 32'h0002_0000);
		wr(8'h08, 4'hF, 32'h0001_2345);
		rdchk(8'h08, 4'hF, 32'h0001_2345);
		wr(8'h0C, 4'hC, 32'h0005_0000);
		rdchk(8'h0C, 4'h3, 32'h0000_0000);
		rdchk(8'h0C, 4'hC, 32'h0005_0000);
		wr(8'h10, 4'h3, 32'h0000_0002);
		check({kick.valid, kick.index}, {1'b1, 16'h0002});
		@(posedge mclk);
		#1;
		queue_event = 1'b1;
		config_event = 1'b1;
		@(posedge mclk);
		#1;
		queue_event = 1'b0;
		config_event = 1'b0;
		check(int_pending, 64'h1);
		rdchk(8'h10, 4'h8, 32'h0300_0000);
		rdchk(8'h10, 4'h8, 32'h0000_0000);
		// Device region after the upper feature words, byte-wise
		wr(8'h1C, 4'h1, 32'h0000_00AA);
		wr(8'h1C, 4'h2, 32'h0000_BB00);
		rdchk(8'h1C, 4'hF, 32'h0000_BBAA);
		rdchk(8'h1C, 4'h2, 32'h0000_BB00);
		stw(8'h00);
		check(accepted, 64'h0);
		msix_enabled = 1'b1;
		rdchk(8'h14, 4'hC, 32'hFFFF_0000);
		rdchk(8'h0C, 4'h3, 32'h0000_0100);
		rdchk(8'h0C, 4'hC, 32'h0000_0000);
		// Mid-run hardware reset clears record and device bytes
		stw(8'h03);
		@(posedge mclk);
		#1 rst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 rst = 1'b0;
		check(driver_status, 64'h0);
		check(config_vector, 64'hFFFF);
		check({kick.valid, soft_reset}, 64'h0);
		rdchk(8'h20, 4'h3, 32'h0000_0000);
		print_verdict();
	end
endmodule
